// ==== src/pds_pkg.sv ====
package pds_pkg;
	// Clock and time base
	localparam int unsigned CLK_HZ          = 20_000_000;   // System clock rate
	localparam int unsigned LAMP_TEST_MS    = 2000;         // Lamp test duration, ms
	localparam int unsigned LAMP_CYCLES     = CLK_HZ / 1000 * LAMP_TEST_MS;
	localparam int unsigned DEBOUNCE_MS     = 10;           // Key settle time, ms
	localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned SEC_CYCLES      = CLK_HZ;       // Cycles per second tick
	localparam int unsigned START_DELAY_MAX = 300;          // Longest start delay, s
	localparam int unsigned SPINUP_RELAY_LIMIT_S   = 480;          // Run-up time limit, s
	localparam logic [6:0]  AT_SPEED_PCT    = 7'h5f;        // 95 % of target speed
	// Register byte offsets
	localparam logic [11:0] CTRL_OFS   = 12'h000;
	localparam logic [11:0] MINSPD_OFS = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;
	// Control register fields and reset values, plus the minimum speed reset value
	localparam int unsigned CTRL_DELAY_LSB = 0;             // Start delay, seconds
	localparam int unsigned CTRL_DELAY_W   = 9;
	localparam int unsigned CTRL_FNO_BIT   = 9;             // Fault relay normally open
	localparam logic [8:0]  CTRL_DELAY_RST = 9'h000;
	localparam logic [6:0]  MINSPD_RST     = 7'h14;         // Minimum speed, percent
	// Conditioned input bit positions
	localparam int unsigned IN_KEY_START = 0;
	localparam int unsigned IN_KEY_STOP  = 1;
	localparam int unsigned IN_KEY_HEAT  = 2;
	localparam int unsigned IN_REM_SEL   = 3;
	localparam int unsigned IN_REM_START = 4;
	localparam int unsigned IN_REM_STOPN = 5;
	localparam int unsigned IN_REM_HEAT  = 6;
	localparam int unsigned IN_COUNT     = 7;
	// Failure codes shown on the LED chain (LED number)
	localparam logic [2:0] FC_SPEED = 3'h3;                 // LED 4: speed fault
	localparam logic [2:0] FC_CONV  = 3'h4;                 // LED 5: converter hot
	localparam logic [2:0] FC_DRIVE = 3'h7;                 // LED 8: bearing/drive
	// Supervisor states
	typedef enum logic [2:0] {
		PDS_LAMP, PDS_STILL, PDS_DELAY, PDS_SPINUP_RELAY,
		PDS_NORMAL, PDS_OVERLOAD, PDS_BRAKE, PDS_FAIL
	} pds_state_type;
endpackage : pds_pkg

// ==== src/pds_in_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Conditioned inputs from the debouncer to the supervisor
interface pds_in_if #(parameter int unsigned N = 7);
	logic [N-1:0] level;                // Settled input levels
	logic [N-1:0] rise;                 // One-cycle pulse on a settled rise
	modport src (output level, output rise);
	modport snk (input level, input rise);
endinterface : pds_in_if
`default_nettype wire

// ==== src/pds_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
module pds_debounce #(
	parameter int unsigned WIDTH      = 7,
	parameter int unsigned DEB_CYCLES = 200_000
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] raw,
	pds_in_if.src                 dq
);
	localparam int unsigned CW = $clog2(DEB_CYCLES + 1);
	localparam logic [CW-1:0] CNT_TOP = CW'(DEB_CYCLES - 1);

	logic [WIDTH-1:0] meta_r;           // First synchroniser stage
	logic [WIDTH-1:0] sync_r;           // Second synchroniser stage
	logic [WIDTH-1:0] stable_r;         // Debounced level
	logic [WIDTH-1:0] rise_r;           // Rise pulse
	logic [CW-1:0]    cnt_r [WIDTH];    // Per-bit settle counters

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser
	always_ff @(posedge clock) begin
		if (!nrst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= raw;
			sync_r <= meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Debounce: a new level must hold for the whole settle time
	always_ff @(posedge clock) begin
		if (!nrst) begin
			stable_r <= '0;
			rise_r   <= '0;
			for (int i = 0; i < WIDTH; i++) begin
				cnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				rise_r[i] <= 1'b0;
				if (sync_r[i] == stable_r[i]) begin
					// Bounce restarts the count
					cnt_r[i] <= '0;
				end else if (cnt_r[i] == CNT_TOP) begin
					stable_r[i] <= sync_r[i];
					rise_r[i]   <= sync_r[i];
					cnt_r[i]    <= '0;
				end else begin
					cnt_r[i] <= cnt_r[i] + CW'(1);
				end
			end
		end
	end

	assign dq.level = stable_r;
	assign dq.rise  = rise_r;
endmodule : pds_debounce
`default_nettype wire

// ==== src/pds_supervisor.sv ====
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pds_supervisor #(
	parameter int unsigned LAMP_CYCLES     = pds_pkg::LAMP_CYCLES,
	parameter int unsigned SEC_CYCLES      = pds_pkg::SEC_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = pds_pkg::DEBOUNCE_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        key_start,
	input  wire logic        key_stop,
	input  wire logic        key_heat,
	input  wire logic        remote_sel,
	input  wire logic        remote_start,
	input  wire logic        remote_stop_n,
	input  wire logic        remote_heat,
	input  wire logic [6:0]  speed_pct,
	input  wire logic [6:0]  current_pct,
	input  wire logic        rotor_standstill,
	input  wire logic        pump_over_temp,
	input  wire logic        conv_over_temp,
	input  wire logic        drive_fault,
	output logic             led_power,
	output logic             led_start,
	output logic             led_stop,
	output logic             led_at_speed,
	output logic             led_overload,
	output logic             led_failure,
	output logic             led_heating,
	output logic      [7:0]  led_chain,
	output logic             vent_relay,
	output logic             heater_relay,
	output logic             cooling_relay,
	output logic             backing_pump_relay,
	output logic             spinup_relay,
	output logic             at_speed_relay,
	output logic             fault_relay,
	output logic             motor_drive,
	output logic             brake_drive,
	output logic             reduce_speed,
	output logic             cable_lock_lamp
);
	localparam int unsigned LW = $clog2(LAMP_CYCLES + 1);
	localparam int unsigned SW = $clog2(SEC_CYCLES + 1);
	localparam logic [LW-1:0] LAMP_TOP  = LW'(LAMP_CYCLES - 1);
	localparam logic [SW-1:0] SEC_TOP   = SW'(SEC_CYCLES - 1);
	localparam logic [SW-1:0] HALF_SEC  = SW'(SEC_CYCLES / 2);
	localparam logic [8:0]    DELAY_MAX = 9'(pds_pkg::START_DELAY_MAX);
	localparam logic [8:0]    SPINUP_RELAY_MAX = 9'(pds_pkg::SPINUP_RELAY_LIMIT_S);

	////////////////////////////////////////////////////////////////////////
	// LED chain helpers

	// Which of the eight chain LEDs a percentage lands on
	function automatic logic [2:0] pct_index(input logic [6:0] pct);
		logic [9:0] scaled;
		scaled = {pct, 3'h0} / 10'h064;
		pct_index = (scaled > 10'h007) ? 3'h7 : scaled[2:0];
	endfunction : pct_index

	// Single lit LED at the speed position
	function automatic logic [7:0] chain_dot(input logic [6:0] pct);
		chain_dot = 8'h01 << pct_index(pct);
	endfunction : chain_dot

	// Bar filled from the bottom up to the current position
	function automatic logic [7:0] chain_bar(input logic [6:0] pct);
		chain_bar = 8'hff >> (3'h7 - pct_index(pct));
	endfunction : chain_bar

	////////////////////////////////////////////////////////////////////////
	// Input conditioning
	pds_in_if #(.N(pds_pkg::IN_COUNT)) cin ();

	pds_debounce #(
		.WIDTH      (pds_pkg::IN_COUNT),
		.DEB_CYCLES (DEBOUNCE_CYCLES)
	) u_debounce (
		.clock (clock),
		.nrst  (nrst),
		.raw   ({remote_heat, remote_stop_n, remote_start, remote_sel,
		         key_heat, key_stop, key_start}),
		.dq    (cin)
	);

	////////////////////////////////////////////////////////////////////////
	// Registers and state
	pds_pkg::pds_state_type state_r;    // Supervisor state
	logic [LW-1:0] lamp_cnt_r;          // Lamp test timer
	logic [SW-1:0] sec_cnt_r;           // Second prescaler
	logic [8:0]    phase_sec_r;         // Seconds in delay or run-up
	logic          heat_sel_r;          // Heating preselected
	logic [2:0]    fail_code_r;         // Latched failure cause
	logic [8:0]    delay_cfg_r;         // Start delay, seconds
	logic          fault_no_r;          // Fault relay wired normally open
	logic [6:0]    min_speed_r;         // Minimum speed, percent

	logic sec_tick;                     // One pulse per second
	logic flash;                        // Half-second blink
	logic remote;                       // Remote control selected
	logic start_cmd;                    // Start request
	logic stop_cmd;                     // Stop request, dominant
	logic at_speed;                     // Speed at or above 95 %
	logic above_min;                    // Speed at or above minimum
	logic running;                      // Motor under drive

	assign sec_tick = (sec_cnt_r == SEC_TOP);
	assign flash    = (sec_cnt_r < HALF_SEC);
	assign at_speed = (speed_pct >= pds_pkg::AT_SPEED_PCT);
	assign above_min = (speed_pct >= min_speed_r);

	////////////////////////////////////////////////////////////////////////
	// Command selection
	assign remote = cin.level[pds_pkg::IN_REM_SEL];
	// Remote start is taken as a level, so a pulse or a held high both work
	assign start_cmd = remote ? cin.level[pds_pkg::IN_REM_START]
	                          : cin.rise[pds_pkg::IN_KEY_START];
	assign stop_cmd  = remote ? !cin.level[pds_pkg::IN_REM_STOPN]
	                          : cin.rise[pds_pkg::IN_KEY_STOP];
	assign running = (state_r == pds_pkg::PDS_SPINUP_RELAY) || (state_r == pds_pkg::PDS_NORMAL)
	              || (state_r == pds_pkg::PDS_OVERLOAD);

	////////////////////////////////////////////////////////////////////////
	// Timers: lamp test, second prescaler, phase seconds
	always_ff @(posedge clock) begin
		if (!nrst) begin
			lamp_cnt_r <= '0;
		end else if (state_r == pds_pkg::PDS_LAMP) begin
			lamp_cnt_r <= lamp_cnt_r + LW'(1);
		end
	end

	// Free-running, so the blink phase never stalls
	always_ff @(posedge clock) begin
		if (!nrst) begin
			sec_cnt_r <= '0;
		end else if (sec_tick) begin
			sec_cnt_r <= '0;
		end else begin
			sec_cnt_r <= sec_cnt_r + SW'(1);
		end
	end

	// Counts whole seconds across the delay and run-up together; cleared only outside those two states
	always_ff @(posedge clock) begin
		if (!nrst) begin
			phase_sec_r <= '0;
		end else if (state_r != pds_pkg::PDS_DELAY && state_r != pds_pkg::PDS_SPINUP_RELAY) begin
			phase_sec_r <= '0;
		end else if (sec_tick && phase_sec_r != 9'h1ff) begin
			phase_sec_r <= phase_sec_r + 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Supervisor state machine; stop is checked first in every state except lamp test and brake
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_r     <= pds_pkg::PDS_LAMP;
			fail_code_r <= '0;
		end else begin
			unique case (state_r)
				pds_pkg::PDS_LAMP: begin
					if (lamp_cnt_r == LAMP_TOP) begin
						state_r <= pds_pkg::PDS_STILL;
					end
				end
				pds_pkg::PDS_STILL: begin
					if (stop_cmd) begin
						state_r <= pds_pkg::PDS_STILL;
					end else if (start_cmd) begin
						// Zero delay goes straight to run-up
						state_r <= (delay_cfg_r == 9'h000) ? pds_pkg::PDS_SPINUP_RELAY
						                                   : pds_pkg::PDS_DELAY;
					end
				end
				pds_pkg::PDS_DELAY: begin
					if (stop_cmd) begin
						state_r <= pds_pkg::PDS_BRAKE;
					end else if (phase_sec_r >= delay_cfg_r) begin
						state_r <= pds_pkg::PDS_SPINUP_RELAY;
					end
				end
				pds_pkg::PDS_SPINUP_RELAY: begin
					if (stop_cmd) begin
						state_r <= pds_pkg::PDS_BRAKE;
					end else if (drive_fault) begin
						state_r     <= pds_pkg::PDS_FAIL;
						fail_code_r <= pds_pkg::FC_DRIVE;
					end else if (at_speed) begin
						state_r <= pds_pkg::PDS_NORMAL;
					end else if (phase_sec_r >= SPINUP_RELAY_MAX) begin
						// Time is up: overload if above minimum, else failure
						state_r <= above_min ? pds_pkg::PDS_OVERLOAD : pds_pkg::PDS_FAIL;
						// Overload is no failure, so only the failing branch latches a cause
						fail_code_r <= above_min ? fail_code_r : pds_pkg::FC_SPEED;
					end
				end
				pds_pkg::PDS_NORMAL, pds_pkg::PDS_OVERLOAD: begin
					if (stop_cmd) begin
						state_r <= pds_pkg::PDS_BRAKE;
					end else if (drive_fault) begin
						state_r     <= pds_pkg::PDS_FAIL;
						fail_code_r <= pds_pkg::FC_DRIVE;
					end else if (!above_min) begin
						state_r     <= pds_pkg::PDS_FAIL;
						fail_code_r <= pds_pkg::FC_SPEED;
					end else if (pump_over_temp || conv_over_temp) begin
						state_r <= pds_pkg::PDS_OVERLOAD;
					end else if (at_speed) begin
						state_r <= pds_pkg::PDS_NORMAL;
					end
				end
				pds_pkg::PDS_BRAKE: begin
					if (rotor_standstill) begin
						state_r <= pds_pkg::PDS_STILL;
					end
				end
				pds_pkg::PDS_FAIL: begin
					// A stop while the rotor still turns leaves the failure latched
					if (stop_cmd && rotor_standstill) begin
						state_r     <= pds_pkg::PDS_STILL;
						fail_code_r <= '0;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Heating preselection
	always_ff @(posedge clock) begin
		if (!nrst) begin
			heat_sel_r <= 1'b0;
		end else if (stop_cmd || state_r == pds_pkg::PDS_FAIL) begin
			heat_sel_r <= 1'b0;
		end else if (remote) begin
			heat_sel_r <= cin.level[pds_pkg::IN_REM_HEAT];
		end else if (cin.rise[pds_pkg::IN_KEY_HEAT]) begin
			heat_sel_r <= !heat_sel_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB register slave: no wait states, error on unmapped address
	always_ff @(posedge clock) begin
		if (!nrst) begin
			delay_cfg_r <= pds_pkg::CTRL_DELAY_RST;
			fault_no_r  <= 1'b0;
			min_speed_r <= pds_pkg::MINSPD_RST;
		end else if (psel && penable && pwrite) begin
			if (paddr == pds_pkg::CTRL_OFS) begin
				// Longer delays are clamped to five minutes
				delay_cfg_r <= (pwdata[8:0] > DELAY_MAX) ? DELAY_MAX : pwdata[8:0];
				fault_no_r  <= pwdata[pds_pkg::CTRL_FNO_BIT];
			end else if (paddr == pds_pkg::MINSPD_OFS) begin
				min_speed_r <= pwdata[6:0];
			end
		end
	end

	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		unique case (paddr)
			pds_pkg::CTRL_OFS: begin
				prdata[pds_pkg::CTRL_DELAY_LSB +: pds_pkg::CTRL_DELAY_W] = delay_cfg_r;
				prdata[pds_pkg::CTRL_FNO_BIT] = fault_no_r;
			end
			pds_pkg::MINSPD_OFS: begin
				prdata[6:0] = min_speed_r;
			end
			pds_pkg::STATUS_OFS: begin
				prdata[2:0]   = state_r;
				prdata[5:3]   = fail_code_r;
				prdata[6]     = heat_sel_r;
				prdata[7]     = remote;
				prdata[14:8]  = {fault_relay, at_speed_relay, spinup_relay,
				                 backing_pump_relay, cooling_relay, heater_relay, vent_relay};
			end
			default: begin
				pslverr = psel && penable;
			end
		endcase
	end
	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Relay decode from the current state
	always_comb begin
		vent_relay         = 1'b0;
		heater_relay       = 1'b0;
		cooling_relay      = 1'b0;
		backing_pump_relay = 1'b0;
		spinup_relay       = 1'b0;
		at_speed_relay     = 1'b0;
		fault_relay        = !fault_no_r;  // Closed at rest in delivered wiring
		unique case (state_r)
			pds_pkg::PDS_DELAY: begin
				vent_relay         = 1'b1;
				backing_pump_relay = 1'b1;
				spinup_relay       = 1'b1;
			end
			pds_pkg::PDS_SPINUP_RELAY: begin
				vent_relay         = 1'b1;
				backing_pump_relay = 1'b1;
				spinup_relay       = 1'b1;
				cooling_relay      = 1'b1;
			end
			pds_pkg::PDS_NORMAL, pds_pkg::PDS_OVERLOAD: begin
				vent_relay         = 1'b1;
				backing_pump_relay = 1'b1;
				cooling_relay      = 1'b1;
				at_speed_relay     = 1'b1;
				heater_relay       = heat_sel_r && (state_r == pds_pkg::PDS_NORMAL);
			end
			pds_pkg::PDS_BRAKE: begin
				cooling_relay = 1'b1;
			end
			pds_pkg::PDS_FAIL: begin
				// Cooling and backing pump open once the rotor stands; the fault relay goes to fault_no_r at once
				cooling_relay      = !rotor_standstill;
				backing_pump_relay = !rotor_standstill;
				fault_relay        = fault_no_r;
			end
			default: begin
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Drive commands
	assign motor_drive     = running;
	assign brake_drive     = ((state_r == pds_pkg::PDS_BRAKE) || (state_r == pds_pkg::PDS_FAIL))
	                      && !rotor_standstill;
	assign reduce_speed    = running && (pump_over_temp || conv_over_temp);
	assign cable_lock_lamp = !rotor_standstill;

	////////////////////////////////////////////////////////////////////////
	// Indicator LEDs
	always_comb begin
		led_power    = 1'b1;
		led_start    = 1'b0;
		led_stop     = 1'b0;
		led_at_speed = 1'b0;
		led_overload = 1'b0;
		led_failure  = 1'b0;
		led_heating  = 1'b0;
		led_chain    = 8'h00;
		unique case (state_r)
			pds_pkg::PDS_LAMP: begin
				{led_start, led_stop, led_at_speed, led_overload} = 4'hf;
				{led_failure, led_heating} = 2'h3;
				led_chain = 8'hff;
			end
			pds_pkg::PDS_STILL: begin
				led_chain = 8'h00;
			end
			pds_pkg::PDS_DELAY: begin
				led_start   = flash;
				led_heating = heat_sel_r && flash;
			end
			pds_pkg::PDS_SPINUP_RELAY: begin
				led_start    = 1'b1;
				led_at_speed = flash;
				led_chain    = chain_dot(speed_pct);
				led_heating  = heat_sel_r && flash;
			end
			pds_pkg::PDS_NORMAL: begin
				led_heating = heat_sel_r;
				if (at_speed) begin
					led_at_speed = 1'b1;
					led_chain    = chain_bar(current_pct);
				end else begin
					led_at_speed = flash;
					led_chain    = chain_dot(speed_pct);
				end
			end
			pds_pkg::PDS_OVERLOAD: begin
				led_overload = 1'b1;
				led_at_speed = flash;
				led_chain    = chain_dot(speed_pct);
			end
			pds_pkg::PDS_BRAKE: begin
				led_stop     = 1'b1;
				led_at_speed = flash;
				led_chain    = chain_dot(speed_pct);
			end
			pds_pkg::PDS_FAIL: begin
				led_failure = 1'b1;
				led_chain   = flash ? (8'h01 << fail_code_r) : 8'h00;
			end
		endcase
	end
endmodule : pds_supervisor
`default_nettype wire

// ==== dv/pds_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// Pin-level watch on the supervisor
module pds_monitor (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic [6:0] speed_pct,
	input wire logic       rotor_standstill,
	input wire logic       led_start,
	input wire logic       led_failure,
	input wire logic [7:0] led_chain,
	input wire logic       vent_relay,
	input wire logic       heater_relay,
	input wire logic       cooling_relay,
	input wire logic       backing_pump_relay,
	input wire logic       spinup_relay,
	input wire logic       at_speed_relay,
	input wire logic       motor_drive,
	input wire logic       brake_drive
);
	// Floor the bench programs before any run
	localparam logic [6:0] MIN_PCT = 7'h1e;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	////////////////////////////////
	property p_lamp; $rose(nrst) |-> led_start && led_chain == 8'hff; endproperty
	a_lamp: assert property (p_lamp) else $error("lamp test dark");
	property p_brake; brake_drive |-> !motor_drive && !heater_relay && !vent_relay; endproperty
	a_brake: assert property (p_brake) else $error("brake overlaps drive");
	property p_heat; heater_relay |-> at_speed_relay; endproperty
	a_heat: assert property (p_heat) else $error("heater off speed");
	property p_spin; spinup_relay |-> backing_pump_relay && vent_relay && !at_speed_relay;
	endproperty
	a_spin: assert property (p_spin) else $error("run-up relays wrong");
	// Standstill seen two edges running, so a late stop sample cannot trip it
	property p_dead; $past(rotor_standstill) && rotor_standstill && led_failure
		|-> !(vent_relay || heater_relay || cooling_relay || backing_pump_relay); endproperty
	a_dead: assert property (p_dead) else $error("relay closed in failure");
	property p_pump; $rose(motor_drive) |-> backing_pump_relay; endproperty
	a_pump: assert property (p_pump) else $error("drive before pump");
	property p_dot; at_speed_relay && speed_pct < 7'h5f |-> $onehot(led_chain); endproperty
	a_dot: assert property (p_dot) else $error("chain not speed");
	property p_low; at_speed_relay && speed_pct < MIN_PCT |=> led_failure && !motor_drive;
	endproperty
	a_low: assert property (p_low) else $error("low speed not failed");
	////////////////////////////////
	c_fail: cover property (led_failure && brake_drive);
	c_brake: cover property (brake_drive && !led_failure);
	c_heat: cover property (heater_relay);
endmodule : pds_monitor
bind pds_supervisor pds_monitor u_mon (.clock, .nrst, .speed_pct, .rotor_standstill,
	.led_start, .led_failure, .led_chain, .vent_relay, .heater_relay, .cooling_relay,
	.backing_pump_relay, .spinup_relay, .at_speed_relay, .motor_drive, .brake_drive);
`default_nettype wire

// ==== dv/pds_pump_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Rotor: one percent per cycle; load cap limits the top speed
module pds_pump_model (
	input  wire logic       clock,
	input  wire logic       motor_drive,
	input  wire logic       brake_drive,
	input  wire logic [6:0] cap,
	output logic      [6:0] speed_pct,
	output logic            rotor_standstill
);
	initial speed_pct = 7'h00;
	// Above the cap the rotor coasts down, so a heavy load really pulls speed down
	always @(posedge clock) begin
		if (motor_drive && speed_pct < cap)
			speed_pct <= speed_pct + 7'h01;
		else if (speed_pct != 7'h00 && (brake_drive || speed_pct > cap))
			speed_pct <= speed_pct - 7'h01;
	end
	assign rotor_standstill = (speed_pct == 7'h00);
endmodule : pds_pump_model
`default_nettype wire

// ==== dv/pump_drive_supervisor_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module pump_drive_supervisor_bench;
	logic        clock, nrst, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        key_start, key_stop, key_heat, remote_sel, remote_start;
	logic        remote_stop_n, remote_heat, pump_over_temp, conv_over_temp, drive_fault;
	logic [6:0]  speed_pct, current_pct, cap;
	logic        rotor_standstill, led_power, led_start, led_stop, led_at_speed;
	logic        led_overload, led_failure, led_heating, vent_relay, heater_relay;
	logic        cooling_relay, backing_pump_relay, spinup_relay, at_speed_relay;
	logic        fault_relay, motor_drive, brake_drive, reduce_speed, cable_lock_lamp;
	logic [7:0]  led_chain;
	int          n_fail, num_checks;
	// Short counts keep the run brief
	pds_supervisor #(.LAMP_CYCLES(20), .SEC_CYCLES(16), .DEBOUNCE_CYCLES(2)) dut (.*);
	pds_pump_model pump (.*);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	// One transfer; answer taken at the edge that samples pready, then a falling edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int   n;
		logic r;
		n = 0;
		r = 1'b0;
		@(posedge clock) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clock) penable <= 1'b1;
		do begin
			@(posedge clock);
			{r, e, q} = {pready, pslverr, prdata};
			n++;
		end while (r !== 1'b1 && n < 20);
		{psel, penable} <= 2'b00;
		if (n >= 20) begin
			n_fail++;
			results();
		end
		@(negedge clock);
	endtask : apb
	// Poll the state field, bounded
	task automatic waitst(input logic [2:0] s, input int lim);
		int n;
		n = 0;
		do begin
			apb(1'b0, pds_pkg::STATUS_OFS, 32'h0);
			n++;
		end while (q[2:0] !== s && n < lim);
		chk("state", q[2:0], s);
		if (q[2:0] !== s)
			results();
	endtask : waitst
	// Keys {heat, stop, start}: held long enough for the debouncer to settle both ways
	task automatic press(input logic [2:0] k);
		@(posedge clock) {key_heat, key_stop, key_start} <= k;
		repeat (8) @(posedge clock);
		{key_heat, key_stop, key_start} <= 3'b000;
		repeat (8) @(posedge clock);
		@(negedge clock);
	endtask : press
	////////////////////////////////
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, key_start, key_stop, key_heat} = '0;
		{remote_sel, remote_start, remote_heat, pump_over_temp, conv_over_temp} = '0;
		{remote_stop_n, drive_fault, current_pct, cap} = {2'b10, 7'h32, 7'h64};
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		chk("lamp", {led_power, led_chain}, 9'h1ff);
		waitst(pds_pkg::PDS_STILL, 30);
		chk("idle", {led_power, led_start, led_stop, led_at_speed}, 4'h8);
		apb(1'b0, pds_pkg::MINSPD_OFS, 32'h0);
		chk("minspd", q, 32'h14);
		apb(1'b1, pds_pkg::MINSPD_OFS, 32'h1e);
		apb(1'b1, pds_pkg::CTRL_OFS, 32'h2);
		apb(1'b1, pds_pkg::STATUS_OFS, 32'h7);
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped err", e, 1'b1);
		chk("unmapped data", q, 32'h0);
		apb(1'b0, pds_pkg::CTRL_OFS, 32'h0);
		chk("ctrl", q, 32'h2);
		waitst(pds_pkg::PDS_STILL, 1);
		// Key start with a two second delay
		press(3'b001);
		waitst(pds_pkg::PDS_DELAY, 10);
		chk("delay", {backing_pump_relay, motor_drive}, 2'b10);
		waitst(pds_pkg::PDS_SPINUP_RELAY, 30);
		waitst(pds_pkg::PDS_NORMAL, 80);
		chk("normal", {led_at_speed, led_start, led_chain}, 10'h21f);
		press(3'b100);
		chk("heat", {heater_relay, led_heating}, 2'b11);
		press(3'b100);
		chk("heat off", heater_relay, 1'b0);
		@(posedge clock) pump_over_temp <= 1'b1;
		waitst(pds_pkg::PDS_OVERLOAD, 5);
		chk("hot", {led_overload, reduce_speed}, 2'b11);
		@(posedge clock) pump_over_temp <= 1'b0;
		waitst(pds_pkg::PDS_NORMAL, 5);
		press(3'b010);
		chk("stop", {motor_drive, brake_drive, vent_relay, backing_pump_relay, led_stop,
			cable_lock_lamp}, 6'b010011);
		waitst(pds_pkg::PDS_STILL, 80);
		chk("still", {led_start, led_stop, led_at_speed}, 3'b000);
		// Remote: keys ignored, start needs stop high, stop dominates a held start
		@(posedge clock) remote_sel <= 1'b1;
		press(3'b001);
		waitst(pds_pkg::PDS_STILL, 1);
		@(posedge clock) remote_start <= 1'b1;
		waitst(pds_pkg::PDS_DELAY, 10);
		// Remote heating level shows up as the preselection bit
		@(posedge clock) remote_heat <= 1'b1;
		repeat (6) @(posedge clock);
		apb(1'b0, pds_pkg::STATUS_OFS, 32'h0);
		chk("remote heat", q[6], 1'b1);
		@(posedge clock) remote_stop_n <= 1'b0;
		waitst(pds_pkg::PDS_STILL, 10);
		chk("heat stop", q[6], 1'b0);
		@(posedge clock) {remote_sel, remote_start, remote_stop_n, remote_heat} <= 4'b0010;
		repeat (8) @(posedge clock);
		// Heavy load: overload after the run-up limit, then failure below minimum
		cap <= 7'h32;
		press(3'b001);
		waitst(pds_pkg::PDS_OVERLOAD, 3000);
		chk("overload code", q[5:3], 3'h0);
		@(posedge clock) cap <= 7'h0a;
		waitst(pds_pkg::PDS_FAIL, 20);
		chk("fail code", q[5:3], pds_pkg::FC_SPEED);
		press(3'b010);
		waitst(pds_pkg::PDS_FAIL, 1);
		for (int i = 0; i < 60 && !rotor_standstill; i++)
			@(posedge clock);
		@(negedge clock);
		chk("dead", {rotor_standstill, vent_relay, heater_relay, cooling_relay,
			backing_pump_relay, spinup_relay, at_speed_relay, fault_relay, cable_lock_lamp,
			led_failure}, 10'h201);
		press(3'b010);
		waitst(pds_pkg::PDS_STILL, 5);
		results();
	end
endmodule : pump_drive_supervisor_bench
`default_nettype wire
